// file: design/dafmt_pkg.sv
// constants and types shared by the dual converter output formatter
package dafmt_pkg;

   // =====================================================================
   // widths
   localparam int unsigned SAMPLE_BITS = 12;
   localparam int unsigned PAIR_LINES  = 6;
   localparam int unsigned ADDR_W      = 4;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned DLY_W       = 2;
   localparam int unsigned DRV_W       = 3;
   localparam int unsigned STS_W       = 3;

   // =====================================================================
   // output modes
   typedef enum logic [1:0]
   {
      DAFMT_MODE_FULL     = 2'b00,
      DAFMT_MODE_DDR_CMOS = 2'b01,
      DAFMT_MODE_DDR_DIFF = 2'b10
   } dafmt_mode_t;

   // =====================================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_STATE  = 4'h3;

   // =====================================================================
   // field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_DLY_LSB  = 2;
   localparam int unsigned CTRL_DRV_LSB  = 4;
   localparam int unsigned CTRL_TERM_BIT = 7;
   localparam int unsigned STS_SMP_BIT   = 0;
   localparam int unsigned STS_OVR1_BIT  = 1;
   localparam int unsigned STS_OVR2_BIT  = 2;
   localparam int unsigned STATE_STRAP_BIT = 2;

   // =====================================================================
   // reset values
   localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
   localparam logic [STS_W-1:0]  MASK_RST = 3'h0;

endpackage

// file: design/dafmt_top.sv
// output formatter of a dual-channel 12-bit sampling converter
//
// Operation
// - Full-rate mode puts each channel's 12-bit result on its own lines, bit 11 the MSB.
// - Full-rate data and range flags change with the forwarded clock's falling edge unless a delay is set.
// - The complementary forwarded clock is always the inverse of the true one.
// - Full-rate mode has one range flag per channel, high for an out-of-range sample.
// - Double-rate modes carry two bits per line, six lines per channel.
// - In double-rate modes a line shows the even bit while the clock is low, the odd bit while high.
// - Double-rate data changes on both clock edges unless a delay is set.
// - The shared range flag shows channel 2 while the clock is low and channel 1 while high.
// - The forwarded clock phase can be delayed against the data in every mode.
// - Differential mode has a configurable drive current level.
// - Differential mode has an optional enabled 100 ohm termination per pair.
// - Differential mode sends data, shared flag and clock as true and complement pairs.
// - Both channels are captured on the same sample clock edge.
// - Mode comes from the control register, or from a strap in parallel style, which cannot pick single-ended double rate.
`timescale 1ns/10ps
`default_nettype none

module dafmt_top
(
   input  wire logic                                 clock,
   input  wire logic                                 nrst,
   input  wire logic [dafmt_pkg::ADDR_W-1:0]         reg_addr,
   input  wire logic [dafmt_pkg::DATA_W-1:0]         reg_wdata,
   input  wire logic                                 reg_wr,
   input  wire logic                                 reg_rd,
   output var  logic [dafmt_pkg::DATA_W-1:0]         reg_rdata,
   output var  logic                                 irq,
   input  wire logic                                 sample_clock_true,
   input  wire logic [dafmt_pkg::SAMPLE_BITS-1:0]    ch1_result,
   input  wire logic [dafmt_pkg::SAMPLE_BITS-1:0]    ch2_result,
   input  wire logic                                 ch1_over,
   input  wire logic                                 ch2_over,
   input  wire logic                                 programming_style_strap,
   input  wire logic                                 mode_strap,
   output var  logic                                 fwd_clock_true,
   output var  logic                                 fwd_clock_comp,
   output var  logic [dafmt_pkg::SAMPLE_BITS-1:0]    ch1_sample_lines,
   output var  logic [dafmt_pkg::SAMPLE_BITS-1:0]    ch2_sample_lines,
   output var  logic                                 ch1_range_flag,
   output var  logic                                 ch2_range_flag,
   output var  logic [dafmt_pkg::PAIR_LINES-1:0]     ch1_paired_lines,
   output var  logic [dafmt_pkg::PAIR_LINES-1:0]     ch2_paired_lines,
   output var  logic [dafmt_pkg::PAIR_LINES-1:0]     ch1_paired_lines_n,
   output var  logic [dafmt_pkg::PAIR_LINES-1:0]     ch2_paired_lines_n,
   output var  logic                                 shared_range_flag,
   output var  logic                                 shared_range_flag_n,
   output var  logic [dafmt_pkg::DRV_W-1:0]          diff_drive_level,
   output var  logic                                 diff_term_en
);

   localparam int unsigned SB = dafmt_pkg::SAMPLE_BITS;
   localparam int unsigned PL = dafmt_pkg::PAIR_LINES;

   // =====================================================================
   // synchronisers
   logic [2:0]    sclk_ff;
   logic [SB-1:0] ch1_meta_ff;
   logic [SB-1:0] ch1_sync_ff;
   logic [SB-1:0] ch2_meta_ff;
   logic [SB-1:0] ch2_sync_ff;
   logic [1:0]    ovr_meta_ff;
   logic [1:0]    ovr_sync_ff;
   logic [1:0]    strap_meta_ff;
   logic [1:0]    strap_sync_ff;
   logic          rise_evt;
   logic          fall_evt;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sclk_ff       <= 3'h0;
         ch1_meta_ff   <= 12'h000;
         ch1_sync_ff   <= 12'h000;
         ch2_meta_ff   <= 12'h000;
         ch2_sync_ff   <= 12'h000;
         ovr_meta_ff   <= 2'h0;
         ovr_sync_ff   <= 2'h0;
         strap_meta_ff <= 2'h0;
         strap_sync_ff <= 2'h0;
      end
      else
      begin
         sclk_ff       <= {sclk_ff[1:0], sample_clock_true};
         ch1_meta_ff   <= ch1_result;
         ch1_sync_ff   <= ch1_meta_ff;
         ch2_meta_ff   <= ch2_result;
         ch2_sync_ff   <= ch2_meta_ff;
         ovr_meta_ff   <= {ch2_over, ch1_over};
         ovr_sync_ff   <= ovr_meta_ff;
         strap_meta_ff <= {programming_style_strap, mode_strap};
         strap_sync_ff <= strap_meta_ff;
      end
   end

   // conversion starts on the rising sample clock edge
   assign rise_evt = sclk_ff[1] & ~sclk_ff[2];
   assign fall_evt = ~sclk_ff[1] & sclk_ff[2];

   // =====================================================================
   // shared capture of both channels
   logic [SB-1:0] hold1_ff;
   logic [SB-1:0] hold2_ff;
   logic [1:0]    hold_ovr_ff;
   logic [SB-1:0] cur1_ff;
   logic [SB-1:0] cur2_ff;
   logic [1:0]    cur_ovr_ff;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         hold1_ff    <= 12'h000;
         hold2_ff    <= 12'h000;
         hold_ovr_ff <= 2'h0;
      end
      else if (rise_evt)
      begin
         hold1_ff    <= ch1_sync_ff;
         hold2_ff    <= ch2_sync_ff;
         hold_ovr_ff <= ovr_sync_ff;
      end
   end

   // sample on display during the current output clock period
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         cur1_ff    <= 12'h000;
         cur2_ff    <= 12'h000;
         cur_ovr_ff <= 2'h0;
      end
      else if (fall_evt)
      begin
         cur1_ff    <= hold1_ff;
         cur2_ff    <= hold2_ff;
         cur_ovr_ff <= hold_ovr_ff;
      end
   end

   a_shared_capture: assert property (@(posedge clock) disable iff (!nrst)
      rise_evt |=> hold1_ff == $past(ch1_sync_ff)
                   && hold2_ff == $past(ch2_sync_ff))
      else $error("channels not captured together");

   // =====================================================================
   // registers
   logic [dafmt_pkg::DATA_W-1:0] ctrl_ff;
   logic [dafmt_pkg::STS_W-1:0]  status_ff;
   logic [dafmt_pkg::STS_W-1:0]  nxt_status;
   logic [dafmt_pkg::STS_W-1:0]  mask_ff;
   logic [dafmt_pkg::DATA_W-1:0] nxt_rdata;
   logic [dafmt_pkg::STS_W-1:0]  events;
   dafmt_pkg::dafmt_mode_t       mode_ff;
   dafmt_pkg::dafmt_mode_t       nxt_mode;
   logic [dafmt_pkg::DLY_W-1:0]  dly_sel;

   assign dly_sel = ctrl_ff[dafmt_pkg::CTRL_DLY_LSB +: dafmt_pkg::DLY_W];
   assign events  = {rise_evt & ovr_sync_ff[1], rise_evt & ovr_sync_ff[0],
                     rise_evt};

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_ff <= dafmt_pkg::CTRL_RST;
         mask_ff <= dafmt_pkg::MASK_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == dafmt_pkg::OFS_CTRL)
            ctrl_ff <= reg_wdata;
         if (reg_addr == dafmt_pkg::OFS_MASK)
            mask_ff <= reg_wdata[dafmt_pkg::STS_W-1:0];
      end
   end

   // read clears, but an event in the same cycle still lands
   always_comb
   begin
      nxt_status = status_ff;
      if (reg_rd && reg_addr == dafmt_pkg::OFS_STATUS)
         nxt_status = 3'h0;
      nxt_status = nxt_status | events;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         status_ff <= 3'h0;
         irq       <= 1'b0;
      end
      else
      begin
         status_ff <= nxt_status;
         irq       <= |(nxt_status & mask_ff);
      end
   end

   always_comb
   begin
      nxt_rdata = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            dafmt_pkg::OFS_CTRL:   nxt_rdata = ctrl_ff;
            dafmt_pkg::OFS_STATUS: nxt_rdata = {5'h00, status_ff};
            dafmt_pkg::OFS_MASK:   nxt_rdata = {5'h00, mask_ff};
            dafmt_pkg::OFS_STATE:  nxt_rdata = {5'h00, strap_sync_ff[1],
                                               mode_ff};
            default:               nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= nxt_rdata;
   end

   // =====================================================================
   // mode selection
   always_comb
   begin
      if (strap_sync_ff[1])
         // strap style cannot reach single-ended double rate
         nxt_mode = strap_sync_ff[0] ? dafmt_pkg::DAFMT_MODE_DDR_DIFF
                                     : dafmt_pkg::DAFMT_MODE_FULL;
      else
      begin
         case (ctrl_ff[dafmt_pkg::CTRL_MODE_LSB +: 2])
            2'h1:    nxt_mode = dafmt_pkg::DAFMT_MODE_DDR_CMOS;
            2'h2:    nxt_mode = dafmt_pkg::DAFMT_MODE_DDR_DIFF;
            default: nxt_mode = dafmt_pkg::DAFMT_MODE_FULL;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         mode_ff <= dafmt_pkg::DAFMT_MODE_FULL;
      else
         mode_ff <= nxt_mode;
   end

   a_strap_no_cmos: assert property (@(posedge clock) disable iff (!nrst)
      strap_sync_ff[1] |=> mode_ff != dafmt_pkg::DAFMT_MODE_DDR_CMOS)
      else $error("strap style picked single-ended double rate");

   // =====================================================================
   // forwarded clock with programmable phase delay
   logic [2:0] dly_chain_ff;
   logic [3:0] taps;

   assign taps = {dly_chain_ff, sclk_ff[1]};

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         dly_chain_ff   <= 3'h0;
         fwd_clock_true <= 1'b0;
         fwd_clock_comp <= 1'b1;
      end
      else
      begin
         dly_chain_ff   <= {dly_chain_ff[1:0], sclk_ff[1]};
         fwd_clock_true <= taps[dly_sel];
         fwd_clock_comp <= ~taps[dly_sel];
      end
   end

   a_comp_inverse: assert property (@(posedge clock) disable iff (!nrst)
      fwd_clock_comp == ~fwd_clock_true)
      else $error("complement clock not inverted");

   a_clock_delay: assert property (@(posedge clock) disable iff (!nrst)
      (fall_evt && dly_sel == 2'h2) ##1 (dly_sel == 2'h2)[*3]
      |-> !fwd_clock_true && $past(fwd_clock_true))
      else $error("forwarded clock delay wrong");

   // =====================================================================
   // even and odd halves per line
   logic [PL-1:0] h1_even;
   logic [PL-1:0] h2_even;
   logic [PL-1:0] c1_odd;
   logic [PL-1:0] c2_odd;

   for (genvar k = 0; k < PL; k++)
   begin : g_pair
      assign h1_even[k] = hold1_ff[2*k];
      assign h2_even[k] = hold2_ff[2*k];
      assign c1_odd[k]  = cur1_ff[2*k+1];
      assign c2_odd[k]  = cur2_ff[2*k+1];
   end

   // =====================================================================
   // output lines
   logic is_full;
   logic is_ddr;
   logic is_diff;

   assign is_full = (mode_ff == dafmt_pkg::DAFMT_MODE_FULL);
   assign is_diff = (mode_ff == dafmt_pkg::DAFMT_MODE_DDR_DIFF);
   assign is_ddr  = ~is_full;

   // full rate: unused lines park low in the other modes
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ch1_sample_lines <= 12'h000;
         ch2_sample_lines <= 12'h000;
         ch1_range_flag   <= 1'b0;
         ch2_range_flag   <= 1'b0;
      end
      else if (!is_full)
      begin
         ch1_sample_lines <= 12'h000;
         ch2_sample_lines <= 12'h000;
         ch1_range_flag   <= 1'b0;
         ch2_range_flag   <= 1'b0;
      end
      else if (fall_evt)
      begin
         ch1_sample_lines <= hold1_ff;
         ch2_sample_lines <= hold2_ff;
         ch1_range_flag   <= hold_ovr_ff[0];
         ch2_range_flag   <= hold_ovr_ff[1];
      end
   end

   a_full_lines: assert property (@(posedge clock) disable iff (!nrst)
      (is_full && fall_evt) ##1 is_full
      |-> ch1_sample_lines == $past(hold1_ff)
          && ch2_sample_lines == $past(hold2_ff)
          && !fwd_clock_true == (dly_sel == 2'h0 || fwd_clock_comp))
      else $error("full-rate lines not updated at falling edge");

   a_full_flags: assert property (@(posedge clock) disable iff (!nrst)
      (is_full && fall_evt) ##1 is_full
      |-> {ch2_range_flag, ch1_range_flag} == $past(hold_ovr_ff))
      else $error("full-rate range flags wrong");

   a_full_quiet: assert property (@(posedge clock) disable iff (!nrst)
      (is_full && !fall_evt) ##1 is_full |-> $stable(ch1_sample_lines))
      else $error("full-rate data moved off the falling edge");

   // double rate: even half on falling edge, odd half on rising edge
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ch1_paired_lines  <= 6'h00;
         ch2_paired_lines  <= 6'h00;
         shared_range_flag <= 1'b0;
      end
      else if (!is_ddr)
      begin
         ch1_paired_lines  <= 6'h00;
         ch2_paired_lines  <= 6'h00;
         shared_range_flag <= 1'b0;
      end
      else if (fall_evt)
      begin
         ch1_paired_lines  <= h1_even;
         ch2_paired_lines  <= h2_even;
         shared_range_flag <= hold_ovr_ff[1];
      end
      else if (rise_evt)
      begin
         ch1_paired_lines  <= c1_odd;
         ch2_paired_lines  <= c2_odd;
         shared_range_flag <= cur_ovr_ff[0];
      end
   end

   // complement rails follow the true rails one for one in differential
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ch1_paired_lines_n  <= 6'h00;
         ch2_paired_lines_n  <= 6'h00;
         shared_range_flag_n <= 1'b0;
      end
      else if (!is_diff)
      begin
         ch1_paired_lines_n  <= 6'h00;
         ch2_paired_lines_n  <= 6'h00;
         shared_range_flag_n <= 1'b0;
      end
      else if (fall_evt)
      begin
         ch1_paired_lines_n  <= ~h1_even;
         ch2_paired_lines_n  <= ~h2_even;
         shared_range_flag_n <= ~hold_ovr_ff[1];
      end
      else if (rise_evt)
      begin
         ch1_paired_lines_n  <= ~c1_odd;
         ch2_paired_lines_n  <= ~c2_odd;
         shared_range_flag_n <= ~cur_ovr_ff[0];
      end
   end

   a_ddr_even: assert property (@(posedge clock) disable iff (!nrst)
      (is_ddr && fall_evt) ##1 is_ddr
      |-> ch1_paired_lines == $past(h1_even)
          && shared_range_flag == $past(hold_ovr_ff[1]))
      else $error("even half or channel 2 flag missing");

   a_ddr_odd: assert property (@(posedge clock) disable iff (!nrst)
      (is_ddr && rise_evt) ##1 is_ddr
      |-> ch2_paired_lines == $past(c2_odd)
          && shared_range_flag == $past(cur_ovr_ff[0]))
      else $error("odd half or channel 1 flag missing");

   a_diff_pairs: assert property (@(posedge clock) disable iff (!nrst)
      (is_diff && (fall_evt || rise_evt)) ##1 is_diff
      |-> ch1_paired_lines_n == ~ch1_paired_lines
          && shared_range_flag_n == ~shared_range_flag)
      else $error("differential rails not complementary");

   // =====================================================================
   // differential drive settings
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         diff_drive_level <= 3'h0;
         diff_term_en     <= 1'b0;
      end
      else
      begin
         diff_drive_level <= is_diff ?
            ctrl_ff[dafmt_pkg::CTRL_DRV_LSB +: dafmt_pkg::DRV_W] : 3'h0;
         diff_term_en     <= is_diff & ctrl_ff[dafmt_pkg::CTRL_TERM_BIT];
      end
   end

   a_term_diff: assert property (@(posedge clock) disable iff (!nrst)
      diff_term_en |-> $past(is_diff) && $past(ctrl_ff[7]))
      else $error("termination on outside differential mode");

endmodule

`default_nettype wire

// file: design/dafmt_pkg_note_unused.sv
// intentionally empty companion file
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: tb/dafmt_rx_model.sv
// receiver model that captures and rebuilds the formatter's output words
`timescale 1ns/10ps
`default_nettype none

module dafmt_rx_model
(
   input  wire logic                              clock,
   input  wire logic                              nrst,
   input  wire logic                              ddr,
   input  wire logic                              fwd_clock_true,
   input  wire logic [dafmt_pkg::SAMPLE_BITS-1:0] ch1_sample_lines,
   input  wire logic [dafmt_pkg::SAMPLE_BITS-1:0] ch2_sample_lines,
   input  wire logic                              ch1_range_flag,
   input  wire logic                              ch2_range_flag,
   input  wire logic [dafmt_pkg::PAIR_LINES-1:0]  ch1_paired_lines,
   input  wire logic [dafmt_pkg::PAIR_LINES-1:0]  ch2_paired_lines,
   input  wire logic                              shared_range_flag,
   output var  logic [dafmt_pkg::SAMPLE_BITS-1:0] rx_ch1,
   output var  logic [dafmt_pkg::SAMPLE_BITS-1:0] rx_ch2,
   output var  logic                              rx_of1,
   output var  logic                              rx_of2,
   output var  logic                              rx_valid
);
   logic                             fwd_ff;
   logic [dafmt_pkg::PAIR_LINES-1:0] even1_ff;
   logic [dafmt_pkg::PAIR_LINES-1:0] even2_ff;
   logic                             of2_ff;

   function automatic logic [dafmt_pkg::SAMPLE_BITS-1:0] weave
   (
      input logic [dafmt_pkg::PAIR_LINES-1:0] ev,
      input logic [dafmt_pkg::PAIR_LINES-1:0] od
   );
      for (int k = 0; k < dafmt_pkg::PAIR_LINES; k++)
      begin
         weave[2*k]   = ev[k];
         weave[2*k+1] = od[k];
      end
   endfunction

   // =====================================================================
   // capture
   // data moves with the forwarded edge, so it is taken a cycle later
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         fwd_ff   <= 1'b0;
         rx_valid <= 1'b0;
      end
      else
      begin
         fwd_ff   <= fwd_clock_true;
         rx_valid <= 1'b0;
         if (fwd_ff && !fwd_clock_true)
         begin
            even1_ff <= ch1_paired_lines;
            even2_ff <= ch2_paired_lines;
            of2_ff   <= shared_range_flag;
            if (!ddr)
            begin
               rx_ch1   <= ch1_sample_lines;
               rx_ch2   <= ch2_sample_lines;
               rx_of1   <= ch1_range_flag;
               rx_of2   <= ch2_range_flag;
               rx_valid <= 1'b1;
            end
         end
         if (!fwd_ff && fwd_clock_true && ddr)
         begin
            rx_ch1   <= weave(even1_ff, ch1_paired_lines);
            rx_ch2   <= weave(even2_ff, ch2_paired_lines);
            rx_of1   <= shared_range_flag;
            rx_of2   <= of2_ff;
            rx_valid <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/dafmt_top_tb.sv
// self-checking bench of the dual converter output formatter
`timescale 1ns/10ps
`default_nettype none

module dafmt_top_tb;
   localparam int SB = dafmt_pkg::SAMPLE_BITS;
   localparam int PL = dafmt_pkg::PAIR_LINES;
   logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [dafmt_pkg::ADDR_W-1:0] reg_addr = '0;
   logic [dafmt_pkg::DATA_W-1:0] reg_wdata = '0, reg_rdata;
   logic sample_clock_true = 1'b0, ch1_over = 1'b0;
   logic ch2_over = 1'b0, programming_style_strap = 1'b0;
   logic mode_strap = 1'b0, irq, fwd_clock_true, fwd_clock_comp;
   logic [SB-1:0] ch1_result = '0, ch2_result = '0;
   logic [SB-1:0] ch1_sample_lines, ch2_sample_lines, rx_ch1, rx_ch2;
   logic ch1_range_flag, ch2_range_flag, shared_range_flag;
   logic [PL-1:0] ch1_paired_lines, ch2_paired_lines;
   logic [PL-1:0] ch1_paired_lines_n, ch2_paired_lines_n;
   logic shared_range_flag_n, diff_term_en, rx_of1, rx_of2, rx_valid;
   logic [dafmt_pkg::DRV_W-1:0] diff_drive_level;
   logic [15:0] rnd = 16'hd158;
   logic [7:0] ctrl_x = 8'h00;
   logic [1:0] ovr_fix = 2'h0;
   logic ovr_rand = 1'b1, armed = 1'b0, fwd_q = 1'b0, fell;
   logic [2*SB+1:0] q[$], exp_cur;
   logic [SB-1:0] last_l;
   int n_fail = 0, tests_run = 0, n_rx = 0, since = 0;
   wire logic [1:0] md;

   // =====================================================================
   // expectation helpers
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // the strap style can only pick full rate or differential double rate
   function automatic logic [1:0] act_mode(input logic sty, input logic ms,
                                           input logic [1:0] cm);
      if (sty)
         return ms ? 2'h2 : 2'h0;
      return (cm == 2'h3) ? 2'h0 : cm;
   endfunction

   assign md = act_mode(programming_style_strap, mode_strap, ctrl_x[1:0]);

   always #12.5 clock = ~clock;

   dafmt_top uut
   (
      .clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .irq, .sample_clock_true, .ch1_result, .ch2_result, .ch1_over,
      .ch2_over, .programming_style_strap, .mode_strap,
      .fwd_clock_true, .fwd_clock_comp, .ch1_sample_lines,
      .ch2_sample_lines, .ch1_range_flag, .ch2_range_flag,
      .ch1_paired_lines, .ch2_paired_lines, .ch1_paired_lines_n,
      .ch2_paired_lines_n, .shared_range_flag, .shared_range_flag_n,
      .diff_drive_level, .diff_term_en
   );

   dafmt_rx_model rx
   (
      .clock, .nrst, .ddr(md != 2'h0), .fwd_clock_true, .ch1_sample_lines,
      .ch2_sample_lines, .ch1_range_flag, .ch2_range_flag,
      .ch1_paired_lines, .ch2_paired_lines, .shared_range_flag,
      .rx_ch1, .rx_ch2, .rx_of1, .rx_of2, .rx_valid
   );

   // =====================================================================
   // tasks
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask

   task automatic summarize;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   // an empty message reads without comparing
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string m);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      @(negedge clock);
      if (m != "")
         chk(reg_rdata === e, m);
   endtask

   task automatic ovr(input logic [1:0] v);
      @(posedge clock);
      ovr_rand = 1'b0;
      ovr_fix  = v;
      ch1_over <= v[0];
      ch2_over <= v[1];
   endtask

   // encode clock stands still between frames so settings never move mid-word
   task automatic frame(input int n);
      n_rx  = 0;
      repeat (n)
      begin
         @(posedge clock);
         sample_clock_true <= 1'b1;
         q.push_back({ch2_over, ch1_over, ch2_result, ch1_result});
         repeat (4) @(posedge clock);
         sample_clock_true <= 1'b0;
         rnd = lfsr(lfsr(rnd));
         ch1_result <= {rnd[11:1], ~ch1_result[0]};
         ch2_result <= {rnd[15:5], ~ch2_result[0]};
         ch1_over <= ovr_rand ? rnd[2] : ovr_fix[0];
         ch2_over <= ovr_rand ? rnd[3] : ovr_fix[1];
         repeat (3) @(posedge clock);
      end
      repeat (16) @(posedge clock);
      chk(n_rx == ((md == 2'h0) ? n : n - 1), "word count");
      chk(q.size() == 0, "words left over");
      // settings change next, the design lags them by a few cycles
      armed = 1'b0;
   endtask

   // =====================================================================
   // output monitor
   always @(posedge clock)
   begin
      fell  = fwd_q && !fwd_clock_true;
      since = (ch1_sample_lines !== last_l) ? 0 : since + 1;
      if (nrst)
         chk(fwd_clock_comp === ~fwd_clock_true, "clock complement");
      if (rx_valid === 1'b1 && armed)
      begin
         n_rx++;
         chk({rx_of2, rx_of1, rx_ch2, rx_ch1} === exp_cur, "word");
      end
      if (fell)
      begin
         if (armed && md == 2'h0)
            chk(since == int'(ctrl_x[3:2]), "clock delay");
         armed = 1'b1;
         if (q.size() > 0)
            exp_cur = q.pop_front();
      end
      if (armed && !programming_style_strap)
      begin
         chk(diff_drive_level === (md == 2'h2 ? ctrl_x[6:4] : 3'h0), "drive");
         chk(diff_term_en === (md == 2'h2 && ctrl_x[7]), "termination");
      end
      if (armed && md == 2'h2)
         chk({ch1_paired_lines_n, ch2_paired_lines_n, shared_range_flag_n}
             === ~{ch1_paired_lines, ch2_paired_lines, shared_range_flag},
             "rails");
      fwd_q  = fwd_clock_true;
      last_l = ch1_sample_lines;
   end

   // =====================================================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      rd(dafmt_pkg::OFS_CTRL, dafmt_pkg::CTRL_RST, "ctrl reset");
      rd(dafmt_pkg::OFS_MASK, {5'h00, dafmt_pkg::MASK_RST}, "mask reset");
      rd(dafmt_pkg::OFS_STATE, 8'h00, "state reset");
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00, "unmapped read");
      rd(dafmt_pkg::OFS_CTRL, 8'h00, "unmapped write");
      for (int m = 0; m < 4; m++)
         for (int d = 0; d < 4; d++)
         begin
            rnd = lfsr(rnd);
            ctrl_x = {rnd[7:4], 2'(d), 2'(m)};
            wr(dafmt_pkg::OFS_CTRL, ctrl_x);
            rd(dafmt_pkg::OFS_CTRL, ctrl_x, "ctrl readback");
            frame(6);
         end
      wr(dafmt_pkg::OFS_MASK, 8'h00);
      ovr(2'b01);
      rd(dafmt_pkg::OFS_STATUS, 8'h00, "");
      frame(2);
      chk(irq === 1'b0, "masked event");
      rd(dafmt_pkg::OFS_STATUS, 8'h03, "ch1 over status");
      rd(dafmt_pkg::OFS_STATUS, 8'h00, "status cleared");
      ovr(2'b10);
      wr(dafmt_pkg::OFS_MASK, 8'h04);
      frame(1);
      chk(irq === 1'b1, "unmasked event");
      rd(dafmt_pkg::OFS_STATUS, 8'h05, "ch2 over status");
      repeat (2) @(posedge clock);
      chk(irq === 1'b0, "irq released");
      programming_style_strap <= 1'b1;
      mode_strap <= 1'b1;
      ctrl_x = 8'h01;
      wr(dafmt_pkg::OFS_CTRL, ctrl_x);
      repeat (4) @(posedge clock);
      rd(dafmt_pkg::OFS_STATE, 8'h06, "strap differential");
      frame(6);
      mode_strap <= 1'b0;
      repeat (4) @(posedge clock);
      rd(dafmt_pkg::OFS_STATE, 8'h04, "strap full rate");
      frame(6);
      summarize;
   end

   initial
   begin
      #100000;
      chk(1'b0, "run timed out");
      summarize;
   end
endmodule
`default_nettype wire
